// File: limit_pkg.sv
// constants, types and register map of the limit threshold monitor
package limit_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int VAL_W = 18;
	localparam int NUM_LIMITS = 4;
	localparam int FAST_LIMITS = 2;
	localparam int ADDR_W = 8;
	localparam int CFG_W = 7;
	localparam logic signed [31:0] SETPOINT_MAX = 32'sh0001869F;
	localparam logic signed [31:0] SETPOINT_MIN = -32'sh0001869F;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_PEAK_MAX = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_PEAK_MIN = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_END = 8'h50;
	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_THR = 4'h4;
	localparam logic [3:0] OFS_BAND = 4'h8;
	localparam logic [3:0] OFS_DEV = 4'hC;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_FAST_BIT = 0;
	localparam int CTRL_LATCH_CLR_BIT = 1;
	localparam int CTRL_PEAK_CLR_BIT = 2;
	localparam int STATUS_IND_LSB = 0;
	localparam int STATUS_DONE_BIT = 8;
	localparam int STATUS_COUNT_LSB = 12;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_SRC_LSB = 2;
	localparam int CFG_LATCH_BIT = 5;
	localparam int CFG_NC_BIT = 6;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		mode_off = 2'h0,
		above_setpoint_mode = 2'h1,
		below_setpoint_mode = 2'h2,
		deviation_mode = 2'h3
	} mode_t;

	typedef enum logic [2:0] {
		net_source = 3'h0,
		gross_source = 3'h1,
		tare_offset_source = 3'h2,
		max_source = 3'h3,
		min_source = 3'h4,
		peak_span = 3'h5
	} source_t;

	typedef struct packed {
		logic relay_nc;
		logic latch_en;
		source_t src;
		mode_t mode;
	} limit_cfg_t;

	typedef struct packed {
		logic signed [VAL_W-1:0] threshold_value;
		logic signed [VAL_W-1:0] dead_band;
		logic signed [VAL_W-1:0] deviation;
	} limit_levels_t;

	localparam limit_cfg_t CFG_RESET = '{relay_nc: 1'b0, latch_en: 1'b0,
		src: net_source, mode: mode_off};
	localparam limit_levels_t LEVELS_RESET = '0;
endpackage

// File: peak_tracker.sv
// running maximum, minimum and span of the net measurement
module peak_tracker
	import limit_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// measurement
	input wire logic sample_valid,
	input wire logic signed [VAL_W-1:0] value,
	input wire logic clear,
	// stored values
	output logic signed [VAL_W-1:0] max_reg,
	output logic signed [VAL_W-1:0] min_reg,
	output logic signed [VAL_W:0] span_reg
);
	logic empty_reg, empty_next;
	logic signed [VAL_W-1:0] max_next, min_next;
	logic signed [VAL_W:0] span_next;

	always_comb begin
		empty_next = empty_reg;
		max_next = max_reg;
		min_next = min_reg;
		if (clear) begin
			empty_next = 1'b1;
			max_next = '0;
			min_next = '0;
		end else if (sample_valid) begin
			empty_next = 1'b0;
			if (empty_reg || value > max_reg) begin
				max_next = value;
			end
			if (empty_reg || value < min_reg) begin
				min_next = value;
			end
		end
		span_next = (VAL_W+1)'(max_next) - (VAL_W+1)'(min_next);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			empty_reg <= 1'b1;
			max_reg <= '0;
			min_reg <= '0;
			span_reg <= '0;
		end else begin
			empty_reg <= empty_next;
			max_reg <= max_next;
			min_reg <= min_next;
			span_reg <= span_next;
		end
	end

	property p_span_tracks;
		@(posedge clk) disable iff (!rst_n)
		span_reg == (VAL_W+1)'(max_reg) - (VAL_W+1)'(min_reg);
	endproperty
	a_span_tracks: assert property (p_span_tracks)
		else $error("span differs from max minus min");
endmodule // peak_tracker

// File: limit_channel.sv
// one limit: comparison, dead band and latching
module limit_channel
	import limit_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic enable,
	input wire limit_cfg_t cfg,
	input wire limit_levels_t lv,
	// measurement
	input wire logic eval,
	input wire logic signed [VAL_W:0] value,
	input wire logic latch_clr,
	// result
	output logic active_reg
);
	// wide enough that value minus set point never wraps
	localparam int CW = VAL_W + 3;
	logic signed [CW-1:0] v, sp, band, dev, diff, mag;
	logic trip, rel, latching, active_next;

	always_comb begin
		v = CW'(value);
		sp = CW'(lv.threshold_value);
		band = CW'(lv.dead_band);
		dev = CW'(lv.deviation);
		diff = v - sp;
		mag = (diff < 0) ? -diff : diff;
		case (cfg.mode)
			above_setpoint_mode: begin
				trip = v > sp;
				rel = v < sp - band;
			end
			below_setpoint_mode: begin
				trip = v < sp;
				rel = v > sp + band;
			end
			deviation_mode: begin
				trip = mag > dev;
				rel = mag < dev - band;
			end
			default: begin
				trip = 1'b0;
				rel = 1'b1;
			end
		endcase
		// a latched low limit could never release, so latching is ignored
		latching = cfg.latch_en && cfg.mode != below_setpoint_mode;
		active_next = active_reg;
		if (!enable || cfg.mode == mode_off) begin
			active_next = 1'b0;
		end else if (eval && trip) begin
			active_next = 1'b1;
		end else if (latch_clr) begin
			active_next = 1'b0;
		end else if (eval && rel && !latching) begin
			active_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_off_idle;
		cfg.mode == mode_off |=> !active_reg;
	endproperty
	a_off_idle: assert property (p_off_idle)
		else $error("limit active while switched off");

	sequence s_high_trip;
		enable && eval && cfg.mode == above_setpoint_mode && v > sp;
	endsequence
	property p_high_trip;
		s_high_trip |=> active_reg;
	endproperty
	a_high_trip: assert property (p_high_trip)
		else $error("high limit did not trip");

	property p_low_trip;
		enable && eval && cfg.mode == below_setpoint_mode && v < sp
			|=> active_reg;
	endproperty
	a_low_trip: assert property (p_low_trip)
		else $error("low limit did not trip");

	property p_dev_trip;
		enable && eval && cfg.mode == deviation_mode && mag > dev
			|=> active_reg;
	endproperty
	a_dev_trip: assert property (p_dev_trip)
		else $error("deviation limit did not trip");

	property p_dead_band;
		enable && eval && cfg.mode == above_setpoint_mode && active_reg
			&& v >= sp - band && !latch_clr |=> active_reg;
	endproperty
	a_dead_band: assert property (p_dead_band)
		else $error("high limit released inside dead band");

	property p_latch_hold;
		enable && latching && active_reg && cfg.mode != mode_off
			&& !latch_clr |=> active_reg;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched limit released without reset");

	property p_low_release;
		enable && eval && cfg.mode == below_setpoint_mode && v > sp + band
			|=> !active_reg;
	endproperty
	a_low_release: assert property (p_low_release)
		else $error("low limit held by latching");
endmodule // limit_channel

// File: limit_threshold_monitor.sv
// set-point limit monitor with an AXI4-Lite register slave
// How it works
// - logic output follows limit indicator exactly
// - four limits, only two in fast build
// - normally-open relay closes while limit active
// - normally-closed relay opens while limit active
// - relay sense defaults to normally open
// - mode defaults off; off never activates
// - high mode trips when value exceeds set point
// - low mode trips when value below set point
// - six selectable sources, net among them
// - gross source ignores zero offsets
// - tare source compares the zero offset
// - max, min or span sources
// - off ends setup (here only a cfg write to the last limit sets setup_done, whatever its mode); last limit finishes setup
// - set point clamps to plus/minus 99999
// - dead band delays release below set point
// - latched limit holds until limit reset
// - latching ignored in low mode
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
module limit_threshold_monitor
	import limit_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// measurement sources
	input wire logic sample_valid,
	input wire logic signed [VAL_W-1:0] net_value,
	input wire logic signed [VAL_W-1:0] gross_value,
	input wire logic signed [VAL_W-1:0] tare_value,
	// limit outputs
	output logic [NUM_LIMITS-1:0] indicator,
	output logic [NUM_LIMITS-1:0] logic_out,
	output logic [NUM_LIMITS-1:0] relay_closed,
	output logic setup_done
);
	localparam logic [1:0] FAST_LAST = 2'(FAST_LIMITS - 1);
	localparam logic [1:0] ALL_LAST = 2'(NUM_LIMITS - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	limit_cfg_t cfg_reg [NUM_LIMITS];
	limit_cfg_t cfg_next [NUM_LIMITS];
	limit_levels_t lv_reg [NUM_LIMITS];
	limit_levels_t lv_next [NUM_LIMITS];
	logic fast_reg, fast_next, latch_clr_reg, latch_clr_next;
	logic peak_clr_reg, peak_clr_next, setup_done_reg, setup_done_next;
	logic [NUM_LIMITS-1:0] active, chan_en;
	logic [NUM_LIMITS-1:0] ind_reg, ind_next, logic_reg, logic_next;
	logic [NUM_LIMITS-1:0] relay_reg, relay_next;
	logic [ADDR_W-1:0] wrel, rrel;
	logic [1:0] widx, ridx;
	logic w_in_lim, r_in_lim;
	logic signed [VAL_W-1:0] peak_max, peak_min;
	logic signed [VAL_W:0] peak_span_val;

	// saturate a written word into the set-point range
	function automatic logic signed [VAL_W-1:0] clamp(
		input logic [31:0] d, input logic allow_neg);
		logic signed [31:0] s;
		logic signed [31:0] lo;
		s = signed'(d);
		lo = allow_neg ? SETPOINT_MIN : 32'sh00000000;
		if (s > SETPOINT_MAX) begin
			s = SETPOINT_MAX;
		end else if (s < lo) begin
			s = lo;
		end
		return s[VAL_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// partial-word writes are refused: the 18-bit level fields span several lanes
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		cfg_next = cfg_reg;
		lv_next = lv_reg;
		fast_next = fast_reg;
		setup_done_next = setup_done_reg;
		latch_clr_next = 1'b0;
		peak_clr_next = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		wrel = awaddr_next - ADDR_LIMIT_BASE;
		widx = wrel[5:4];
		w_in_lim = awaddr_next >= ADDR_LIMIT_BASE
			&& awaddr_next < ADDR_LIMIT_END;
		if (aw_held_next && w_held_next && !bvalid_reg) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_SLVERR;
			if (wstrb_next != 4'hF) begin
				bresp_next = RESP_SLVERR;
			end else if (awaddr_next == ADDR_CTRL) begin
				bresp_next = RESP_OKAY;
				fast_next = wdata_next[CTRL_FAST_BIT];
				latch_clr_next = wdata_next[CTRL_LATCH_CLR_BIT];
				peak_clr_next = wdata_next[CTRL_PEAK_CLR_BIT];
			end else if (w_in_lim && !(fast_reg && widx > FAST_LAST)) begin
				bresp_next = RESP_OKAY;
				case (wrel[3:0])
					OFS_CFG: begin
						if (wdata_next[CFG_SRC_LSB+:3] > peak_span) begin
							bresp_next = RESP_SLVERR;
						end else begin
							cfg_next[widx] = '{
								relay_nc: wdata_next[CFG_NC_BIT],
								latch_en: wdata_next[CFG_LATCH_BIT],
								src: source_t'(wdata_next[CFG_SRC_LSB+:3]),
								mode: mode_t'(wdata_next[CFG_MODE_LSB+:2])};
							setup_done_next = widx == (fast_reg ?
								FAST_LAST : ALL_LAST);
						end
					end
					OFS_THR: begin
						lv_next[widx].threshold_value =
							clamp(wdata_next, 1'b1);
					end
					OFS_BAND: begin
						lv_next[widx].dead_band = clamp(wdata_next, 1'b0);
					end
					OFS_DEV: begin
						lv_next[widx].deviation = clamp(wdata_next, 1'b0);
					end
					default: begin
						bresp_next = RESP_SLVERR;
					end
				endcase
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_held_next;
		wready_next = !w_held_next;
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_comb begin
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		rrel = s_axi_araddr - ADDR_LIMIT_BASE;
		ridx = rrel[5:4];
		r_in_lim = s_axi_araddr >= ADDR_LIMIT_BASE
			&& s_axi_araddr < ADDR_LIMIT_END;
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = '0;
			if (s_axi_araddr == ADDR_CTRL) begin
				rdata_next[CTRL_FAST_BIT] = fast_reg;
			end else if (s_axi_araddr == ADDR_STATUS) begin
				rdata_next[STATUS_IND_LSB+:NUM_LIMITS] = ind_reg;
				rdata_next[STATUS_DONE_BIT] = setup_done_reg;
				rdata_next[STATUS_COUNT_LSB+:3] = fast_reg ?
					3'(FAST_LIMITS) : 3'(NUM_LIMITS);
			end else if (s_axi_araddr == ADDR_PEAK_MAX) begin
				rdata_next = 32'(peak_max);
			end else if (s_axi_araddr == ADDR_PEAK_MIN) begin
				rdata_next = 32'(peak_min);
			end else if (r_in_lim) begin
				case (rrel[3:0])
					OFS_CFG: rdata_next[CFG_W-1:0] = cfg_reg[ridx];
					OFS_THR: rdata_next = 32'(lv_reg[ridx].threshold_value);
					OFS_BAND: rdata_next = 32'(lv_reg[ridx].dead_band);
					OFS_DEV: rdata_next = 32'(lv_reg[ridx].deviation);
					default: rresp_next = RESP_SLVERR;
				endcase
			end else begin
				rresp_next = RESP_SLVERR;
			end
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	// ----------------------------------------------------------------
	// sources and limits
	// ----------------------------------------------------------------
	peak_tracker u_peak (
		.clk(clk),
		.rst_n(rst_n),
		.sample_valid(sample_valid),
		.value(net_value),
		.clear(peak_clr_reg),
		.max_reg(peak_max),
		.min_reg(peak_min),
		.span_reg(peak_span_val)
	);

	for (genvar i = 0; i < NUM_LIMITS; i++) begin : g_lim
		logic signed [VAL_W:0] src_val;
		always_comb begin
			case (cfg_reg[i].src)
				net_source: src_val = (VAL_W+1)'(net_value);
				gross_source: src_val = (VAL_W+1)'(gross_value);
				tare_offset_source: src_val = (VAL_W+1)'(tare_value);
				max_source: src_val = (VAL_W+1)'(peak_max);
				min_source: src_val = (VAL_W+1)'(peak_min);
				peak_span: src_val = peak_span_val;
				default: src_val = (VAL_W+1)'(net_value);
			endcase
		end
		assign chan_en[i] = !fast_reg || i < FAST_LIMITS;
		limit_channel u_chan (
			.clk(clk),
			.rst_n(rst_n),
			.enable(chan_en[i]),
			.cfg(cfg_reg[i]),
			.lv(lv_reg[i]),
			.eval(sample_valid),
			.value(src_val),
			.latch_clr(latch_clr_reg),
			.active_reg(active[i])
		);
	end

	// absent relays of the fast build stay open
	always_comb begin
		for (int i = 0; i < NUM_LIMITS; i++) begin
			ind_next[i] = active[i] && chan_en[i];
			logic_next[i] = active[i] && chan_en[i];
			relay_next[i] = chan_en[i]
				&& (active[i] ^ cfg_reg[i].relay_nc);
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= '0;
			for (int i = 0; i < NUM_LIMITS; i++) begin
				cfg_reg[i] <= CFG_RESET;
				lv_reg[i] <= LEVELS_RESET;
			end
			fast_reg <= 1'b0;
			latch_clr_reg <= 1'b0;
			peak_clr_reg <= 1'b0;
			setup_done_reg <= 1'b0;
			ind_reg <= '0;
			logic_reg <= '0;
			relay_reg <= '0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			cfg_reg <= cfg_next;
			lv_reg <= lv_next;
			fast_reg <= fast_next;
			latch_clr_reg <= latch_clr_next;
			peak_clr_reg <= peak_clr_next;
			setup_done_reg <= setup_done_next;
			ind_reg <= ind_next;
			logic_reg <= logic_next;
			relay_reg <= relay_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign indicator = ind_reg;
	assign logic_out = logic_reg;
	assign relay_closed = relay_reg;
	assign setup_done = setup_done_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_logic_follows;
		logic_reg == ind_reg;
	endproperty
	a_logic_follows: assert property (p_logic_follows)
		else $error("logic output differs from indicator");

	property p_relay_sense;
		relay_reg[0] == (ind_reg[0] ^ $past(cfg_reg[0].relay_nc));
	endproperty
	a_relay_sense: assert property (p_relay_sense)
		else $error("relay contact sense wrong");

	property p_fast_quiet;
		fast_reg |=> ind_reg[NUM_LIMITS-1:FAST_LIMITS] == '0
			&& relay_reg[NUM_LIMITS-1:FAST_LIMITS] == '0;
	endproperty
	a_fast_quiet: assert property (p_fast_quiet)
		else $error("unfitted limit active in fast build");

	sequence s_sample_trip;
		sample_valid && chan_en[0] && !latch_clr_reg
			&& cfg_reg[0].mode == above_setpoint_mode
			&& g_lim[0].src_val > lv_reg[0].threshold_value;
	endsequence
	property p_sample_eval;
		s_sample_trip |=> ##1 ind_reg[0];
	endproperty
	a_sample_eval: assert property (p_sample_eval)
		else $error("sample did not reach indicator in two cycles");
endmodule // limit_threshold_monitor

// File: limit_far_side.sv
// far-side model: relay contacts and logic inputs of external equipment
module limit_far_side
	import limit_pkg::*;
(
	// clock
	input wire logic clk,
	// limit outputs seen from outside
	input wire logic [NUM_LIMITS-1:0] logic_out,
	input wire logic [NUM_LIMITS-1:0] relay_closed,
	// what the external equipment has latched
	output logic [NUM_LIMITS-1:0] contact_reg,
	output logic [NUM_LIMITS-1:0] ttl_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	// a slow reader: it only sees settled levels, never glitches
	always_ff @(posedge clk) begin
		contact_reg <= relay_closed;
		ttl_reg <= logic_out;
	end
endmodule // limit_far_side

// File: limit_threshold_monitor_tb.sv
// self-checking bench of the limit threshold monitor
module limit_threshold_monitor_tb
	import limit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, sv, done;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, r;
	logic signed [VAL_W-1:0] net, gross, tare;
	logic [3:0] ind, lout, rly, cont, ttl, strb;
	int fail_count, cmp_count;
	typedef struct {mode_t m; source_t s; logic nc; int v; logic e;} row_t;
	row_t rows[14] = '{
		'{above_setpoint_mode, net_source, 0, 500, 1},
		'{above_setpoint_mode, net_source, 0, 50, 0},
		'{below_setpoint_mode, net_source, 1, 50, 1},
		'{below_setpoint_mode, net_source, 0, 500, 0},
		'{above_setpoint_mode, gross_source, 0, -500, 1},
		'{above_setpoint_mode, tare_offset_source, 0, 400, 1},
		'{above_setpoint_mode, tare_offset_source, 0, 100, 0},
		'{deviation_mode, net_source, 0, 111, 1},
		'{deviation_mode, net_source, 1, 105, 0},
		'{deviation_mode, net_source, 0, 89, 1},
		'{mode_off, net_source, 0, 500, 0},
		'{above_setpoint_mode, max_source, 0, 0, 1},
		'{below_setpoint_mode, min_source, 0, 0, 1},
		'{above_setpoint_mode, peak_span, 0, 0, 1}};
	limit_threshold_monitor limit_threshold_monitor_i (.clk(clk),
		.rst_n(rst_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.sample_valid(sv), .net_value(net), .gross_value(gross),
		.tare_value(tare), .indicator(ind), .logic_out(lout),
		.relay_closed(rly), .setup_done(done));
	limit_far_side limit_far_side_i (.clk(clk), .logic_out(lout),
		.relay_closed(rly), .contact_reg(cont), .ttl_reg(ttl));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= d;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		r = bresp;
		bready <= 0;
		if (n >= 50) begin
			fail_count++;
			conclude();
		end
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		rd = rdata;
		r = rresp;
		rready <= 0;
		if (n >= 50) begin
			fail_count++;
			conclude();
		end
	endtask
	// outputs settle two edges after the sample edge; one spare
	task automatic smp(input int v);
		@(posedge clk);
		sv <= 1;
		net <= v;
		gross <= -v;
		tare <= v / 2;
		@(posedge clk);
		sv <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic cfg0(input mode_t m, source_t s, logic nc, logic la);
		limit_cfg_t c;
		c = '{relay_nc: nc, latch_en: la, src: s, mode: m};
		wr(8'h10, {25'h0, c});
	endtask
	task automatic out0(input logic e, nc);
		chk("ind0", ind[0], e);
		chk("lout0", lout[0], e);
		chk("rly0", rly[0], e ^ nc);
		chk("contact0", cont[0], e ^ nc);
		chk("ttl0", ttl[0], e);
	endtask
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		conclude();
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, sv} = '0;
		{awaddr, araddr, wdata, net, gross, tare} = '0;
		strb = 4'hF;
		repeat (16) @(posedge clk);
		rst_n <= 1;
		chk("rly", rly, 4'h0);
		wr(8'h14, 32'd100);
		wr(8'h1C, 32'd10);
		foreach (rows[i]) begin
			cfg0(rows[i].m, rows[i].s, rows[i].nc, 0);
			smp(rows[i].v);
			out0(rows[i].e, rows[i].nc);
		end
		// stored extremes of the net samples, then their clear
		rdr(8'h08);
		chk("max", rd, 32'd500);
		rdr(8'h0C);
		chk("min", rd, 32'hFFFFFE0C);
		wr(8'h00, 32'h4);
		rdr(8'h08);
		chk("maxclr", rd, 32'h0);
		// dead band: release only below set point minus band
		wr(8'h18, 32'd10);
		cfg0(above_setpoint_mode, net_source, 0, 0);
		smp(150);
		smp(95);
		out0(1, 0);
		smp(85);
		out0(0, 0);
		// latching holds until limit reset, except in low mode
		cfg0(above_setpoint_mode, net_source, 0, 1);
		smp(500);
		smp(0);
		out0(1, 0);
		wr(8'h00, 32'h2);
		repeat (3) @(posedge clk);
		out0(0, 0);
		cfg0(below_setpoint_mode, net_source, 0, 1);
		smp(0);
		smp(500);
		out0(0, 0);
		// set point saturates; unmapped place refused
		wr(8'h14, 32'd200000);
		strb <= 4'h3;
		wr(8'h14, 32'd5);
		chk("strb", r, RESP_SLVERR);
		strb <= 4'hF;
		rdr(8'h14);
		chk("thr", rd, 32'h0001869F);
		wr(8'h10, 32'h18);
		chk("srcref", r, RESP_SLVERR);
		rdr(8'hFC);
		chk("unmapped", r, RESP_SLVERR);
		// setup finishes on the last fitted limit
		wr(8'h40, 32'h0);
		chk("done4", done, 1);
		wr(8'h00, 32'h1);
		rdr(8'h04);
		chk("count", rd[14:12], 2);
		wr(8'h30, 32'h1);
		chk("fastref", r, RESP_SLVERR);
		wr(8'h20, 32'h0);
		chk("done2", done, 1);
		chk("rly32", rly[3:2], 2'h0);
		// mid-run reset clears a latched, closed-sense limit
		wr(8'h00, 32'h0);
		wr(8'h14, 32'd100);
		cfg0(above_setpoint_mode, net_source, 1, 1);
		smp(500);
		out0(1, 1);
		rst_n <= 0;
		repeat (16) @(posedge clk);
		rst_n <= 1;
		chk("ind", ind, 4'h0);
		chk("rly", rly, 4'h0);
		rdr(8'h10);
		chk("cfg", rd, 32'h0);
		conclude();
	end
endmodule // limit_threshold_monitor_tb
